//--- verilog/eil_encoder_index_event_latch.sv
// index event detection and position latching for a quadrature encoder
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns

// How it works
// - config bit 10 picks fraction base 65536 when clear, 10000 when set.
// - config bit 9 also captures ramp position on each latching index event.
// - clear-on-index at 0: index event only copies encoder position to latch.
// - clear-on-index at 1: latch the position and zero the counter.
// - both edge bits zero: event active for as long as condition holds.
// - rising bit fires entering, falling bit leaving, both bits fire either way.
// - single-shot bit: act only on first event after configuration write.
// - continuous bit: act on every qualifying index event.
// - ignore bit clear: N, A and B must all match their polarities.
// - ignore bit set: condition formed from N polarity alone.
// - bit 2 sets N active level, 0 low, 1 high.
// - bit 1 sets required B level, 0 low, 1 high.
// - bit 0 sets required A level, 0 low, 1 high.
// - every index event sets read-to-clear status bit 0, feeding interrupt.
// - each up step adds signed 16.16 increment, each down step subtracts it.
// - readable latch holds position captured at latest latching event.
module eil_encoder_index_event_latch
    import eil_pkg::*;
#(
    parameter int POS_W = 32
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_n,
    input wire logic [POS_W-1:0] ramp_actual_position,
    input wire logic [eil_pkg::ADDR_W-1:0] addr,
    input wire logic [eil_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [eil_pkg::DATA_W-1:0] rd_data,
    output logic irq
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [2:0] pins_sync;
    logic a_s;
    logic b_s;
    logic n_s;
    logic [CFG_W-1:0] config_reg;
    logic [DATA_W-1:0] increment_reg;
    logic [STATUS_W-1:0] status_reg;
    logic [STATUS_W-1:0] status_next;
    logic [STATUS_W-1:0] mask_reg;
    logic [POS_W-1:0] latch_reg;
    logic [POS_W-1:0] ramp_latch_reg;
    logic [POS_W-1:0] position;
    logic a_prev_reg;
    logic b_prev_reg;
    logic cond_prev_reg;
    logic cond;
    logic a_match;
    logic b_match;
    logic n_match;
    logic step;
    logic step_up;
    logic index_event;
    logic latch_enable;
    logic latch_fire;
    logic [1:0] edge_sel;
    logic cfg_write;
    logic status_read;
    eil_shot_t shot_reg;
    eil_shot_t shot_next;
    logic [DATA_W-1:0] read_mux;

    // ----------------------------------------------------------------
    // address decode helper
    // ----------------------------------------------------------------
    // exact match of the full address; partial decode would alias others
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] offset);
        reg_hit = (a == offset);
    endfunction

    assign cfg_write = wr_en && reg_hit(addr, ADDR_CONFIG);
    assign status_read = rd_en && reg_hit(addr, ADDR_STATUS);

    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    // encoder pins are asynchronous to clk; two stages before any use
    eil_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .async_in({enc_n, enc_b, enc_a}),
        .sync_out(pins_sync)
    );

    assign a_s = pins_sync[0];
    assign b_s = pins_sync[1];
    assign n_s = pins_sync[2];

    // ----------------------------------------------------------------
    // quadrature step decode
    // ----------------------------------------------------------------
    // previous sampled A and B levels
    always_ff @(posedge clk) begin
        if (srst) begin
            a_prev_reg <= 1'b0;
            b_prev_reg <= 1'b0;
        end else begin
            a_prev_reg <= a_s;
            b_prev_reg <= b_s;
        end
    end

    // a step is one channel changing; both at once is a glitch and is dropped
    always_comb begin
        step = (a_s ^ a_prev_reg) ^ (b_s ^ b_prev_reg);
        step_up = a_prev_reg ^ b_s;
    end

    // ----------------------------------------------------------------
    // position accumulator
    // ----------------------------------------------------------------
    // increment register holds a signed 16.16 value
    eil_accum #(
        .POS_W(POS_W)
    ) u_accum (
        .clk(clk),
        .srst(srst),
        .step(step),
        .step_up(step_up),
        .decimal(config_reg[BIT_DECIMAL]),
        .inc_int(increment_reg[DATA_W-1:FRAC_W]),
        .inc_frac(increment_reg[FRAC_W-1:0]),
        .clear(latch_fire && config_reg[BIT_CLEAR_ON_INDEX]),
        .load(wr_en && reg_hit(addr, ADDR_POSITION)),
        .load_value(wr_data[POS_W-1:0]),
        .position(position)
    );

    // ----------------------------------------------------------------
    // index condition
    // ----------------------------------------------------------------
    // polarity matches against the configured levels
    always_comb begin
        n_match = (n_s == config_reg[BIT_POL_N]);
        b_match = (b_s == config_reg[BIT_POL_B]);
        a_match = (a_s == config_reg[BIT_POL_A]);
        if (config_reg[BIT_IGNORE_QUADRATURE_LEVELS]) begin
            cond = n_match;
        end else begin
            cond = n_match && a_match && b_match;
        end
    end

    // previous condition for transition detection
    always_ff @(posedge clk) begin
        if (srst) begin
            cond_prev_reg <= 1'b0;
        end else begin
            cond_prev_reg <= cond;
        end
    end

    // ----------------------------------------------------------------
    // event sensitivity
    // ----------------------------------------------------------------
    // level mode repeats every cycle, so continuous latching wants edges
    always_comb begin
        edge_sel = {config_reg[BIT_EDGE_INACTIVE], config_reg[BIT_EDGE_ACTIVE]};
        case (edge_sel)
            EDGE_LEVEL: begin
                index_event = cond;
            end
            EDGE_ACTIVE: begin
                index_event = cond && !cond_prev_reg;
            end
            EDGE_INACTIVE: begin
                index_event = !cond && cond_prev_reg;
            end
            EDGE_BOTH: begin
                index_event = cond ^ cond_prev_reg;
            end
            default: begin
                index_event = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // single shot arming
    // ----------------------------------------------------------------
    // a config write re-arms; a new write beats an event in the same cycle
    always_comb begin
        shot_next = shot_reg;
        case (shot_reg)
            SHOT_IDLE: begin
                if (cfg_write && wr_data[BIT_SINGLE_SHOT]) begin
                    shot_next = SHOT_ARMED;
                end
            end
            SHOT_ARMED: begin
                if (cfg_write) begin
                    shot_next = wr_data[BIT_SINGLE_SHOT] ? SHOT_ARMED : SHOT_IDLE;
                end else if (index_event) begin
                    shot_next = SHOT_IDLE;
                end
            end
            default: begin
                shot_next = SHOT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            shot_reg <= SHOT_IDLE;
        end else begin
            shot_reg <= shot_next;
        end
    end

    // latch only when continuous, or when a single shot is still armed
    always_comb begin
        latch_enable = config_reg[BIT_CONTINUOUS]
                    || (config_reg[BIT_SINGLE_SHOT] && shot_reg == SHOT_ARMED);
        latch_fire = index_event && latch_enable;
    end

    // ----------------------------------------------------------------
    // position latches
    // ----------------------------------------------------------------
    // captures the value before any clear lands in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            latch_reg <= '0;
        end else if (latch_fire) begin
            latch_reg <= position;
        end
    end

    // ramp position taken on the same event as the encoder position
    always_ff @(posedge clk) begin
        if (srst) begin
            ramp_latch_reg <= '0;
        end else if (latch_fire && config_reg[BIT_LATCH_RAMP]) begin
            ramp_latch_reg <= ramp_actual_position;
        end
    end

    // ----------------------------------------------------------------
    // software writable registers
    // ----------------------------------------------------------------
    // configuration
    always_ff @(posedge clk) begin
        if (srst) begin
            config_reg <= CFG_RESET;
        end else if (cfg_write) begin
            config_reg <= wr_data[CFG_W-1:0];
        end
    end

    // increment constant, write only
    always_ff @(posedge clk) begin
        if (srst) begin
            increment_reg <= '0;
        end else if (wr_en && reg_hit(addr, ADDR_INCREMENT)) begin
            increment_reg <= wr_data;
        end
    end

    // interrupt mask
    always_ff @(posedge clk) begin
        if (srst) begin
            mask_reg <= MASK_RESET;
        end else if (wr_en && reg_hit(addr, ADDR_IRQ_MASK)) begin
            mask_reg <= wr_data[STATUS_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // status and interrupt
    // ----------------------------------------------------------------
    // an event in the reading cycle survives the clear
    always_comb begin
        status_next = status_reg;
        if (status_read) begin
            status_next = '0;
        end
        if (index_event) begin
            status_next[BIT_INDEX_EVENT] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            status_reg <= STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // irq follows the stored flags one cycle late to stay registered
    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_reg & mask_reg);
        end
    end

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    // unmapped and write-only offsets read as zero
    always_comb begin
        read_mux = '0;
        case (addr)
            ADDR_CONFIG: begin
                read_mux = DATA_W'(config_reg);
            end
            ADDR_POSITION: begin
                read_mux = DATA_W'(position);
            end
            ADDR_STATUS: begin
                read_mux = DATA_W'(status_reg);
            end
            ADDR_LATCH: begin
                read_mux = DATA_W'(latch_reg);
            end
            ADDR_RAMP_LATCH: begin
                read_mux = DATA_W'(ramp_latch_reg);
            end
            ADDR_IRQ_MASK: begin
                read_mux = DATA_W'(mask_reg);
            end
            default: begin
                read_mux = '0;
            end
        endcase
    end

    // data valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= read_mux;
        end else begin
            rd_data <= '0;
        end
    end

endmodule

//--- inc/eil_pkg.sv
// shared constants and types for the encoder index event latch
package eil_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h38;
    localparam logic [ADDR_W-1:0] ADDR_POSITION = 8'h39;
    localparam logic [ADDR_W-1:0] ADDR_INCREMENT = 8'h3A;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h3B;
    localparam logic [ADDR_W-1:0] ADDR_LATCH = 8'h3C;
    localparam logic [ADDR_W-1:0] ADDR_RAMP_LATCH = 8'h3D;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h3E;

    // ----------------------------------------------------------------
    // configuration field layout
    // ----------------------------------------------------------------
    localparam int CFG_W = 11;
    localparam int BIT_POL_A = 0;
    localparam int BIT_POL_B = 1;
    localparam int BIT_POL_N = 2;
    localparam int BIT_IGNORE_QUADRATURE_LEVELS = 3;
    localparam int BIT_CONTINUOUS = 4;
    localparam int BIT_SINGLE_SHOT = 5;
    localparam int BIT_EDGE_ACTIVE = 6;
    localparam int BIT_EDGE_INACTIVE = 7;
    localparam int BIT_CLEAR_ON_INDEX = 8;
    localparam int BIT_LATCH_RAMP = 9;
    localparam int BIT_DECIMAL = 10;
    localparam logic [CFG_W-1:0] CFG_RESET = 11'h000;

    // edge select as {inactive going, active going}
    localparam logic [1:0] EDGE_LEVEL = 2'h0;
    localparam logic [1:0] EDGE_ACTIVE = 2'h1;
    localparam logic [1:0] EDGE_INACTIVE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ----------------------------------------------------------------
    // status and interrupt layout
    // ----------------------------------------------------------------
    localparam int STATUS_W = 1;
    localparam int BIT_INDEX_EVENT = 0;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 1'h0;
    localparam logic [STATUS_W-1:0] MASK_RESET = 1'h1;

    // ----------------------------------------------------------------
    // position arithmetic
    // ----------------------------------------------------------------
    localparam int FRAC_W = 16;
    localparam int INT_W = 16;
    localparam logic [FRAC_W:0] MOD_BINARY = 17'h10000;
    localparam logic [FRAC_W:0] MOD_DECIMAL = 17'h02710;

    // single shot arming
    typedef enum logic [0:0] {
        SHOT_IDLE = 1'b0,
        SHOT_ARMED = 1'b1
    } eil_shot_t;

endpackage

//--- verilog/eil_sync.sv
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
module eil_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    genvar i;
    // one chain per pin; first stage feeds nothing but the second
    generate
        for (i = 0; i < WIDTH; i++) begin : g_chain
            logic meta_reg;
            always_ff @(posedge clk) begin
                if (srst) begin
                    meta_reg <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_reg <= async_in[i];
                    sync_out[i] <= meta_reg;
                end
            end
        end
    endgenerate

endmodule

//--- verilog/eil_accum.sv
// fixed-point encoder position accumulator, binary or decimal fraction
`timescale 1ns/1ns
module eil_accum
    import eil_pkg::*;
#(
    parameter int POS_W = 32
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic step,
    input wire logic step_up,
    input wire logic decimal,
    input wire logic [eil_pkg::INT_W-1:0] inc_int,
    input wire logic [eil_pkg::FRAC_W-1:0] inc_frac,
    input wire logic clear,
    input wire logic load,
    input wire logic [POS_W-1:0] load_value,
    output logic [POS_W-1:0] position
);

    logic [FRAC_W-1:0] frac_reg;
    logic [FRAC_W-1:0] frac_next;
    logic [POS_W-1:0] pos_next;
    logic [FRAC_W:0] modulus;
    logic [FRAC_W:0] sum;
    logic [FRAC_W:0] diff;
    logic carry;
    logic [POS_W-1:0] whole;

    // fraction wraps at 65536 or 10000; the carry moves into the integer
    always_comb begin
        modulus = decimal ? MOD_DECIMAL : MOD_BINARY;
        sum = {1'b0, frac_reg} + {1'b0, inc_frac};
        diff = {1'b0, frac_reg} - {1'b0, inc_frac};
        whole = {{(POS_W-INT_W){inc_int[INT_W-1]}}, inc_int};
        if (step_up) begin
            carry = (sum >= modulus);
            frac_next = carry ? FRAC_W'(sum - modulus) : sum[FRAC_W-1:0];
            pos_next = position + whole + POS_W'(carry);
        end else begin
            carry = diff[FRAC_W];
            frac_next = carry ? FRAC_W'(diff + modulus) : diff[FRAC_W-1:0];
            pos_next = position - whole - POS_W'(carry);
        end
    end

    // clear beats a software load, which beats a step
    always_ff @(posedge clk) begin
        if (srst || clear) begin
            position <= '0;
            frac_reg <= '0;
        end else if (load) begin
            position <= load_value;
            frac_reg <= '0;
        end else if (step) begin
            position <= pos_next;
            frac_reg <= frac_next;
        end
    end

endmodule

//--- dv/eil_asserts.sv
// port-level assertion checker for the encoder index event latch
`timescale 1ns/1ns
module eil_checker
    import eil_pkg::*;
#(
    parameter int POS_W = 32
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_n,
    input wire logic [POS_W-1:0] ramp_actual_position,
    input wire logic [eil_pkg::ADDR_W-1:0] addr,
    input wire logic [eil_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [eil_pkg::DATA_W-1:0] rd_data,
    input wire logic irq
);
    // ------------
    // bus read properties
    // ------------
    // all checks share the one clock and its reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_RD_IDLE_ZERO: assert property (!$past(rd_en) |-> rd_data == 32'h0)
        else $error("read data not zero outside read slot");
    AST_UNMAPPED_ZERO: assert property (rd_en && addr > ADDR_IRQ_MASK |=> rd_data == 32'h0)
        else $error("unmapped read not zero");
    AST_INC_WRITE_ONLY: assert property (rd_en && addr == ADDR_INCREMENT |=> rd_data == 32'h0)
        else $error("increment read not zero");
    AST_CFG_READBACK: assert property (wr_en && addr == ADDR_CONFIG ##1 rd_en && addr == ADDR_CONFIG
        |=> rd_data == ($past(wr_data, 2) & 32'h7FF))
        else $error("config readback differs from written value");
    AST_CFG_UPPER: assert property (rd_en && addr == ADDR_CONFIG |=> rd_data[31:11] == 21'h0)
        else $error("config upper bits not zero");
    AST_STATUS_UPPER: assert property (rd_en && addr == ADDR_STATUS |=> rd_data[31:1] == 31'h0)
        else $error("status upper bits not zero");

    // ------------
    // interrupt properties
    // ------------
    AST_MASK_READBACK: assert property (wr_en && addr == ADDR_IRQ_MASK ##1
        rd_en && addr == ADDR_IRQ_MASK |=> rd_data == ($past(wr_data, 2) & 32'h1))
        else $error("mask readback differs from written value");
    AST_MASKED_IRQ: assert property (wr_en && addr == ADDR_IRQ_MASK && !wr_data[0]
        ##1 !(wr_en && addr == ADDR_IRQ_MASK) |=> !irq)
        else $error("interrupt high while masked");
endmodule

bind eil_encoder_index_event_latch eil_checker #(.POS_W(POS_W)) i_eil_checker (
    .clk(clk), .srst(srst), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n),
    .ramp_actual_position(ramp_actual_position), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq)
);

//--- dv/eil_enc_model.sv
// quadrature encoder with index channel, moved by bench commands
`timescale 1ns/1ns
module eil_enc_model (
    input wire logic clk,
    output logic enc_a,
    output logic enc_b,
    output logic enc_n
);
    int phase = 0;

    // ------------
    // channel drive
    // ------------
    // push-pull outputs, so idle levels simply hold
    initial begin
        enc_a = 1'b0;
        enc_b = 1'b0;
        enc_n = 1'b0;
    end

    // gray order 00 01 11 10 counts up; hold long enough for the synchroniser
    task automatic step(input bit up);
        @(posedge clk);
        phase = up ? (phase + 1) % 4 : (phase + 3) % 4;
        enc_a <= phase[1];
        enc_b <= phase[1] ^ phase[0];
        repeat (4) @(posedge clk);
    endtask

    // index level change, held six clocks
    task automatic set_n(input logic lvl);
        @(posedge clk);
        enc_n <= lvl;
        repeat (6) @(posedge clk);
    endtask
endmodule

//--- dv/eil_encoder_index_event_latch_tb.sv
// self-checking bench for the encoder index event latch
`timescale 1ns/1ns
module eil_encoder_index_event_latch_tb;
    import eil_pkg::*;
    logic clk = 1'b0;
    logic srst;
    logic [31:0] ramp_pos;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [DATA_W-1:0] rd_data;
    logic irq;
    logic enc_a;
    logic enc_b;
    logic enc_n;
    int error_cnt = 0;
    int total_checks = 0;
    logic [15:0] seed = 16'h0044;
    int m_pos = 0;
    int m_frac = 0;
    int m_inc_i = 0;
    int m_inc_f = 0;
    int m_mod = 65536;
    logic [2:0] exp_edge [4] = '{3'h7, 3'h4, 3'h1, 3'h5};

    // ------------
    // clock and instances
    // ------------
    always #50 clk = ~clk;

    eil_enc_model i_eil_enc_model (.clk(clk), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));

    eil_encoder_index_event_latch #(.POS_W(32)) i_eil_encoder_index_event_latch (
        .clk(clk), .srst(srst), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n),
        .ramp_actual_position(ramp_pos), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq)
    );

    // ------------
    // helpers
    // ------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // bus cycles: one-cycle strobes, read data taken in the following cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    // write then read the same place with no gap
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        q = rd_data;
    endtask

    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        rd(a, q);
        chk(n, q, e);
    endtask

    // reference accumulator: fraction wraps at the selected base
    task automatic do_step(input bit up);
        int c;
        i_eil_enc_model.step(up);
        m_frac = up ? m_frac + m_inc_f : m_frac - m_inc_f;
        c = (m_frac >= m_mod) ? 1 : (m_frac < 0) ? -1 : 0;
        m_frac -= c * m_mod;
        m_pos += (up ? m_inc_i : -m_inc_i) + c;
    endtask

    task automatic set_inc(input logic [31:0] d);
        wr(ADDR_INCREMENT, d);
        m_inc_i = $signed(d[31:16]);
        m_inc_f = d[15:0];
    endtask

    task automatic setpos(input logic [31:0] p);
        wr(ADDR_POSITION, p);
        m_pos = p;
        m_frac = 0;
    endtask

    task automatic pulse();
        i_eil_enc_model.set_n(1'b1);
        i_eil_enc_model.set_n(1'b0);
    endtask

    // status after rising index, while held, and after falling index
    task automatic idx(input logic [10:0] cfg, input logic [2:0] e);
        logic [31:0] q;
        wr(ADDR_CONFIG, {21'h0, cfg});
        repeat (4) @(posedge clk);
        rd(ADDR_STATUS, q);
        i_eil_enc_model.set_n(1'b1);
        rd(ADDR_STATUS, q);
        chk("event rise", q, {31'h0, e[2]});
        rd(ADDR_STATUS, q);
        chk("event hold", q, {31'h0, e[1]});
        i_eil_enc_model.set_n(1'b0);
        rd(ADDR_STATUS, q);
        chk("event fall", q, {31'h0, e[0]});
    endtask

    // ------------
    // main sequence
    // ------------
    initial begin
        logic [31:0] q;
        logic [1:0] ab;
        srst <= 1'b1;
        ramp_pos <= 32'h0;
        addr <= 8'h00;
        wr_data <= 32'h0;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rc("config", ADDR_CONFIG, 32'h0);
        rc("mask", ADDR_IRQ_MASK, 32'h1);
        rc("status", ADDR_STATUS, 32'h1);
        rc("latch", ADDR_LATCH, 32'h0);
        rc("unmapped", 8'h40, 32'h0);
        rc("increment", ADDR_INCREMENT, 32'h0);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            wr_rd(ADDR_CONFIG, {16'h0, seed}, q);
            chk("config rb", q, {21'h0, seed[10:0]});
        end
        // stepping in binary then decimal fraction base
        wr(ADDR_CONFIG, 32'h0);
        set_inc(32'h0001_8000);
        setpos(32'h0);
        repeat (3) do_step(1'b1);
        rc("pos up", ADDR_POSITION, 32'd4);
        do_step(1'b0);
        rc("pos down", ADDR_POSITION, 32'd3);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            do_step(seed[0]);
        end
        rc("pos walk", ADDR_POSITION, m_pos);
        wr(ADDR_CONFIG, 32'h400);
        m_mod = 10000;
        set_inc(32'h0000_1388);
        setpos(32'h0);
        repeat (2) do_step(1'b1);
        rc("pos decimal", ADDR_POSITION, 32'd1);
        // every edge mode, then quadrature polarity matching
        for (int m = 0; m < 4; m++) begin
            idx(11'(12 + m * 64), exp_edge[m]);
        end
        ab = {i_eil_enc_model.phase[1] ^ i_eil_enc_model.phase[0], i_eil_enc_model.phase[1]};
        for (int p = 0; p < 4; p++) begin
            idx({9'h011, p[1:0]}, (p == ab) ? 3'h4 : 3'h0);
        end
        idx({9'h013, ~ab}, 3'h4);
        idx(11'h048, 3'h1);
        // latch only with ramp position captured alongside, then latch with clear-on-index
        seed = lfsr(seed);
        @(posedge clk);
        ramp_pos <= {seed, 16'h1234};
        setpos({16'h0, seed});
        wr(ADDR_CONFIG, 32'h25C);
        pulse();
        rc("latch", ADDR_LATCH, m_pos);
        rc("ramp latch", ADDR_RAMP_LATCH, {seed, 16'h1234});
        rc("pos kept", ADDR_POSITION, m_pos);
        setpos(32'h0000_0ABC);
        wr(ADDR_CONFIG, 32'h15C);
        pulse();
        rc("latch again", ADDR_LATCH, 32'h0000_0ABC);
        rc("pos cleared", ADDR_POSITION, 32'h0);
        // single shot acts once per configuration write
        wr(ADDR_CONFIG, 32'h16C);
        setpos(32'd7);
        pulse();
        rc("shot pos", ADDR_POSITION, 32'h0);
        setpos(32'd9);
        pulse();
        rc("shot spent", ADDR_POSITION, 32'd9);
        rc("shot latch", ADDR_LATCH, 32'd7);
        // interrupt raised, masked, unmasked and cleared by reading
        rc("status", ADDR_STATUS, 32'h1);
        i_eil_enc_model.set_n(1'b1);
        chk("irq set", {31'h0, irq}, 32'h1);
        wr(ADDR_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr_rd(ADDR_IRQ_MASK, 32'h1, q);
        chk("mask rb", q, 32'h1);
        rc("status held", ADDR_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq clear", {31'h0, irq}, 32'h0);
        final_report();
    end

    // hang guard, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        final_report();
    end
endmodule
